// >>> common/srwg_consts.svh
`ifndef SRWG_CONSTS_SVH
`define SRWG_CONSTS_SVH
// Reset hold time choices in microseconds; the device figures are left to integration
`define SRWG_CLK_MHZ        50
`define SRWG_HOLD_US_0      1000
`define SRWG_HOLD_US_1      10000
`define SRWG_HOLD_US_2      100000
`define SRWG_HOLD_US_3      200000
`define SRWG_CNT_W          24
`define SRWG_TSEL_RST       2'h1
`define SRWG_LOCK_OPEN      2'h0
`endif

// >>> common/srwg_pkg.sv
`default_nettype none
package srwg_pkg;
	typedef enum logic [1:0] {
		SRWG_ST_HOLD    = 2'b00,
		SRWG_ST_COUNT   = 2'b01,
		SRWG_ST_RUN     = 2'b10
	} srwg_state_t;
	typedef logic [1:0] srwg_sel_t;
endpackage
`default_nettype wire

// >>> rtl/srwg_supervisor.sv
`default_nettype none
`include "srwg_consts.svh"
module srwg_supervisor
	import srwg_pkg::*;
#(
	parameter int unsigned HOLD_CYC_0 = `SRWG_HOLD_US_0 * `SRWG_CLK_MHZ,
	parameter int unsigned HOLD_CYC_1 = `SRWG_HOLD_US_1 * `SRWG_CLK_MHZ,
	parameter int unsigned HOLD_CYC_2 = `SRWG_HOLD_US_2 * `SRWG_CLK_MHZ,
	parameter int unsigned HOLD_CYC_3 = `SRWG_HOLD_US_3 * `SRWG_CLK_MHZ
) (
	input  wire logic            clock_i,
	input  wire logic            rst_b_i,
	input  wire logic            supply_low_i,
	input  wire logic            manual_reset_in_i,
	input  wire logic            aux_above_i,
	input  wire srwg_pkg::srwg_sel_t timeout_sel_i,
	input  wire logic            timeout_sel_we_i,
	input  wire logic            write_protect_i,
	input  wire srwg_pkg::srwg_sel_t sector_lock_i,
	input  wire logic            nv_write_req_i,
	input  wire logic            vol_write_req_i,
	output logic                 supply_reset_o,
	output logic                 aux_monitor_flag_o,
	output logic [1:0]           timeout_sel_o,
	output logic                 nv_write_ok_o,
	output logic                 vol_write_ok_o
);
	import srwg_pkg::*;

	localparam logic [`SRWG_CNT_W-1:0] HC0 = HOLD_CYC_0[`SRWG_CNT_W-1:0];
	localparam logic [`SRWG_CNT_W-1:0] HC1 = HOLD_CYC_1[`SRWG_CNT_W-1:0];
	localparam logic [`SRWG_CNT_W-1:0] HC2 = HOLD_CYC_2[`SRWG_CNT_W-1:0];
	localparam logic [`SRWG_CNT_W-1:0] HC3 = HOLD_CYC_3[`SRWG_CNT_W-1:0];

	srwg_state_t             state_q, state_d;
	logic [`SRWG_CNT_W-1:0]  cnt_q, cnt_d;
	logic [1:0]              sel_q, sel_d;
	logic [`SRWG_CNT_W-1:0]  hold_len;
	logic                    cause;
	logic                    done;
	logic                    rst_d;
	logic [`SRWG_CNT_W-1:0]  quiet_q;

	// Timeout select register, software writable
	assign sel_d = timeout_sel_we_i ? timeout_sel_i : sel_q;
	assign hold_len = (sel_q == 2'h0) ? HC0 :
	                  (sel_q == 2'h1) ? HC1 :
	                  (sel_q == 2'h2) ? HC2 : HC3;
	// Any cause of reset
	assign cause = supply_low_i || manual_reset_in_i;
	assign done  = (cnt_q >= hold_len - 24'h000001);

	// Next state and count
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			SRWG_ST_HOLD: begin
				cnt_d = '0;
				if (!cause) begin
					state_d = SRWG_ST_COUNT;
				end
			end
			SRWG_ST_COUNT: begin
				if (cause) begin
					state_d = SRWG_ST_HOLD;
					cnt_d   = '0;
				end else if (done) begin
					state_d = SRWG_ST_RUN;
				end else begin
					cnt_d = cnt_q + 24'h000001;
				end
			end
			SRWG_ST_RUN: begin
				cnt_d = '0;
				if (cause) begin
					state_d = SRWG_ST_HOLD;
				end
			end
			default: begin
				state_d = SRWG_ST_HOLD;
				cnt_d   = '0;
			end
		endcase
	end
	// Reset stays high unless running and no cause
	assign rst_d = !((state_d == SRWG_ST_RUN) && !cause);

	// State registers, reset output starts active
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q        <= SRWG_ST_HOLD;
			cnt_q          <= '0;
			sel_q          <= `SRWG_TSEL_RST;
			supply_reset_o <= 1'b1;
		end else begin
			state_q        <= state_d;
			cnt_q          <= cnt_d;
			sel_q          <= sel_d;
			supply_reset_o <= rst_d;
		end
	end

	// Aux flag follows comparator, registered only
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aux_monitor_flag_o <= 1'b0;
			timeout_sel_o      <= `SRWG_TSEL_RST;
		end else begin
			aux_monitor_flag_o <= aux_above_i;
			timeout_sel_o      <= sel_d;
		end
	end

	// Write gating
	srwg_write_guard u_guard (
		.clock_i         (clock_i),
		.rst_b_i         (rst_b_i),
		.write_protect_i (write_protect_i),
		.sector_lock_i   (sector_lock_i),
		.nv_write_req_i  (nv_write_req_i),
		.vol_write_req_i (vol_write_req_i),
		.nv_write_ok_o   (nv_write_ok_o),
		.vol_write_ok_o  (vol_write_ok_o)
	);

	// Cycles the reset has stood with no cause, used by the hold-length release check below
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quiet_q <= '0;
		end else if (cause || !supply_reset_o) begin
			quiet_q <= '0;
		end else begin
			quiet_q <= quiet_q + 24'h000001;
		end
	end

	// Reset follows a low main supply
	property p_low_resets;
		@(posedge clock_i) disable iff (!rst_b_i) supply_low_i |=> supply_reset_o;
	endproperty
	a_low_resets: assert property (p_low_resets) else $error("reset not active on low supply");

	// Manual reset forces reset regardless of supply
	property p_mr_resets;
		@(posedge clock_i) disable iff (!rst_b_i) manual_reset_in_i |=> supply_reset_o;
	endproperty
	a_mr_resets: assert property (p_mr_resets) else $error("reset not active on manual reset");

	// Manual reset release never drops the reset at once
	property p_hold_min;
		@(posedge clock_i) disable iff (!rst_b_i) $fell(manual_reset_in_i) && !supply_low_i |=> supply_reset_o;
	endproperty
	a_hold_min: assert property (p_hold_min) else $error("reset released without hold");

	// Release only from a finished count
	property p_release_full;
		@(posedge clock_i) disable iff (!rst_b_i) $fell(supply_reset_o) |-> $past(state_q) == SRWG_ST_COUNT && $past(done);
	endproperty
	a_release_full: assert property (p_release_full) else $error("release before full count");

	// A new cause during the count starts it over
	property p_restart;
		@(posedge clock_i) disable iff (!rst_b_i) (state_q == SRWG_ST_COUNT && cause) |=> cnt_q == '0 && state_q == SRWG_ST_HOLD;
	endproperty
	a_restart: assert property (p_restart) else $error("count not restarted");

	// Shortest select picks the shortest hold
	property p_sel_len;
		@(posedge clock_i) disable iff (!rst_b_i) (sel_q == 2'h0) |-> hold_len == HC0;
	endproperty
	a_sel_len: assert property (p_sel_len) else $error("hold length not from select");

	// A written select shows on the select output one edge later
	property p_sel_write;
		@(posedge clock_i) disable iff (!rst_b_i) timeout_sel_we_i |=> timeout_sel_o == $past(timeout_sel_i);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("written select not applied");

	// Measured quiet time before release covers the selected hold
	property p_hold_len;
		@(posedge clock_i) disable iff (!rst_b_i) $fell(supply_reset_o) |-> quiet_q > $past(hold_len);
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("release before selected hold length");

	// Reset stands whenever the sequencer is not running
	property p_not_run_high;
		@(posedge clock_i) disable iff (!rst_b_i) state_q != SRWG_ST_RUN |-> supply_reset_o;
	endproperty
	a_not_run_high: assert property (p_not_run_high) else $error("reset low outside run state");

	// Running with no cause keeps the reset released
	property p_run_clear;
		@(posedge clock_i) disable iff (!rst_b_i) (state_q == SRWG_ST_RUN && !cause) |=> !supply_reset_o;
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("reset held with no cause");

	// Aux flag copies the comparator high
	property p_aux_hi;
		@(posedge clock_i) disable iff (!rst_b_i) aux_above_i |=> aux_monitor_flag_o;
	endproperty
	a_aux_hi: assert property (p_aux_hi) else $error("aux flag not high");

	// Aux flag copies the comparator low
	property p_aux_lo;
		@(posedge clock_i) disable iff (!rst_b_i) !aux_above_i |=> !aux_monitor_flag_o;
	endproperty
	a_aux_lo: assert property (p_aux_lo) else $error("aux flag not low");

	// Main scenarios to be reached
	c_release: cover property (@(posedge clock_i) disable iff (!rst_b_i) $fell(supply_reset_o));
	c_restart: cover property (@(posedge clock_i) disable iff (!rst_b_i) state_q == SRWG_ST_COUNT && cause);
	c_nv_write: cover property (@(posedge clock_i) disable iff (!rst_b_i) nv_write_ok_o);
	c_mr_release: cover property (@(posedge clock_i) disable iff (!rst_b_i) $fell(manual_reset_in_i) && !supply_low_i);
	c_sel_long: cover property (@(posedge clock_i) disable iff (!rst_b_i) timeout_sel_we_i && timeout_sel_i == 2'h3);
endmodule
`default_nettype wire

// >>> rtl/srwg_write_guard.sv
`default_nettype none
`include "srwg_consts.svh"
module srwg_write_guard
	import srwg_pkg::*;
(
	input  wire logic      clock_i,
	input  wire logic      rst_b_i,
	input  wire logic      write_protect_i,
	input  wire srwg_pkg::srwg_sel_t sector_lock_i,
	input  wire logic      nv_write_req_i,
	input  wire logic      vol_write_req_i,
	output logic           nv_write_ok_o,
	output logic           vol_write_ok_o
);
	import srwg_pkg::*;
	logic  lock_active;
	logic  nv_ok_d;
	logic  vol_ok_d;
	// Full lock when protect is high and sector lock not open
	assign lock_active = write_protect_i && (sector_lock_i != `SRWG_LOCK_OPEN);
	assign nv_ok_d     = nv_write_req_i && !write_protect_i;
	assign vol_ok_d    = vol_write_req_i && !lock_active;
	// Registered grants
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nv_write_ok_o  <= 1'b0;
			vol_write_ok_o <= 1'b0;
		end else begin
			nv_write_ok_o  <= nv_ok_d;
			vol_write_ok_o <= vol_ok_d;
		end
	end
	property p_nv_block;
		@(posedge clock_i) disable iff (!rst_b_i) write_protect_i |=> !nv_write_ok_o;
	endproperty
	a_nv_block: assert property (p_nv_block) else $error("nv write passed under protect");
	property p_vol_block;
		@(posedge clock_i) disable iff (!rst_b_i) lock_active |=> !vol_write_ok_o;
	endproperty
	a_vol_block: assert property (p_vol_block) else $error("volatile write passed under lock");
	property p_vol_pass;
		@(posedge clock_i) disable iff (!rst_b_i) (vol_write_req_i && !write_protect_i) |=> vol_write_ok_o;
	endproperty
	a_vol_pass: assert property (p_vol_pass) else $error("volatile write wrongly blocked");
endmodule
`default_nettype wire

// >>> test/srwg_host_model.sv
`default_nettype none
// Host reset pin: measures how long each reset pulse holds the processor off
module srwg_host_model (
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	input  wire logic supply_reset_i,
	output int        last_len_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_q;
	// Count high cycles, latch the length when the pin drops
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 0;
			last_len_o <= 0;
		end else if (supply_reset_i) begin
			cnt_q <= cnt_q + 1;
		end else if (cnt_q != 0) begin
			last_len_o <= cnt_q;
			cnt_q <= 0;
		end
	end
endmodule
`default_nettype wire

// >>> test/srwg_supervisor_tb.sv
`default_nettype none
module srwg_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import srwg_pkg::*;
	logic clock_i, rst_b_i, low, mr, aux, we, wp, nv, vol, r_o, f_o, nv_ok, vol_ok;
	logic [1:0] s_o;
	logic [2:0] exp_q, exp_n;
	logic [5:0] rnd;
	srwg_sel_t sel, lock;
	int fails, check_count, len;
	int hold[4] = '{8, 16, 32, 64};
	srwg_supervisor #(.HOLD_CYC_0(8), .HOLD_CYC_1(16), .HOLD_CYC_2(32), .HOLD_CYC_3(64)) uut (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .supply_low_i(low), .manual_reset_in_i(mr),
		.aux_above_i(aux), .timeout_sel_i(sel), .timeout_sel_we_i(we), .write_protect_i(wp),
		.sector_lock_i(lock), .nv_write_req_i(nv), .vol_write_req_i(vol), .supply_reset_o(r_o),
		.aux_monitor_flag_o(f_o), .timeout_sel_o(s_o), .nv_write_ok_o(nv_ok), .vol_write_ok_o(vol_ok));
	srwg_host_model host (.clock_i(clock_i), .rst_b_i(rst_b_i), .supply_reset_i(r_o), .last_len_o(len));
	// Grant expected from protect and lock
	function automatic logic [1:0] exp_grant(logic p, srwg_sel_t l, logic n, logic v);
		return {n & ~p, v & ~(p & (l != 2'h0))};
	endfunction
	task automatic test_done();
		if (fails == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check_bits(logic [2:0] got, logic [2:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic check_len(int exp);
		check_count++;
		if (len != exp) begin
			fails++;
			$display("[FAIL] %0t pulse %0d expected %0d", $time, len, exp);
		end
	endtask
	// Wait bounded for reset release, then check the measured pulse
	task automatic wait_release(int lo);
		for (int i = 0; i < lo + 10 && r_o !== 1'b0; i++) @(posedge clock_i) #1;
		if (r_o !== 1'b0) begin
			fails++;
			$display("[FAIL] %0t reset never released", $time);
			test_done();
		end
		@(posedge clock_i) #1;
		check_len(lo);
	endtask
	// Hold a cause c+1 cycles, optionally retrigger mid-count; pulse spans cause plus hold
	task automatic pulse(bit use_mr, int c, bit re, int n);
		@(posedge clock_i) if (use_mr) mr <= 1'b1; else low <= 1'b1;
		repeat (c) @(posedge clock_i);
		#1 check_bits(r_o, 1'b1);
		@(posedge clock_i) {mr, low} <= 2'b00;
		if (re) begin
			repeat (3) @(posedge clock_i);
			mr <= 1'b1;
			repeat (2) @(posedge clock_i);
			mr <= 1'b0;
		end
		#1 wait_release(c + 1 + n + (re ? 5 : 0));
	endtask
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	initial begin
		{rst_b_i, low, mr, aux, we, wp, nv, vol, sel, lock} = '0;
		fails = 0;
		check_count = 0;
		void'($urandom(32'h7922));
		repeat (4) @(posedge clock_i);
		#1 check_bits({r_o, s_o}, 3'b101);
		check_bits({f_o, nv_ok, vol_ok}, 3'b000);
		@(posedge clock_i) rst_b_i <= 1'b1;
		#1 wait_release(hold[1] + 1);
		for (int s = 3; s >= 0; s--) begin
			@(posedge clock_i) {we, sel} <= {1'b1, 2'(s)};
			@(posedge clock_i) we <= 1'b0;
			#1 check_bits(s_o, 3'(s));
			pulse(1'b1, s + 1, 1'b0, hold[s]);
		end
		pulse(1'b0, 6, 1'b0, hold[0]);
		pulse(1'b0, 2, 1'b1, hold[0]);
		// Drive at the edge, check one edge later; first two are protect corner cases
		for (int i = 0; i < 300; i++) begin
			@(posedge clock_i);
			rnd = 6'($urandom);
			if (i < 2) rnd = i ? 6'h17 : 6'h33;
			aux <= rnd[5];
			{wp, lock, nv, vol} <= rnd[4:0];
			exp_n = {rnd[5], exp_grant(rnd[4], rnd[3:2], rnd[1], rnd[0])};
			#1;
			if (i > 0) begin
				check_bits(f_o, exp_q[2]);
				check_bits({nv_ok, vol_ok}, exp_q[1:0]);
			end
			exp_q = exp_n;
		end
		test_done();
	end
endmodule
`default_nettype wire
